/* rtl/special_codec_pkg.sv */
// Operation
// [RQ1] Select high sends listed K-character by disparity
// [RQ2] Unlisted special codes are reserved, never presented
// [RQ3] Special code is binary value on data pins
// [RQ4] Idle: one negative K28.5, else four-character sequence
// [RQ5] Host holds Idle four byte times or multiples
// [RQ6] Ready: one negative K28.5, else four-character sequence
// [RQ7] Host holds Ready four byte times or multiples
// [RQ8] Decoder never outputs Idle or Ready codes
// [RQ9] Exception code sends disparity-correct invalid character
// [RQ10] C1.7 forces negative K28.5; decoded on RD+
// [RQ11] C2.7 forces positive K28.5; decoded on RD-
// [RQ12] C4.7 sends and reports running disparity violation
// [RQ13] Both ends track running disparity every character
package special_codec_pkg;

  localparam int BYTE_W = 8;
  localparam int SYM_W = 10;

  // ----------------------------------------------------------------
  // Special character codes on the parallel data pins
  // ----------------------------------------------------------------
  localparam logic [7:0] SC_K_LAST = 8'h0B;
  localparam logic [7:0] SC_K28_5 = 8'h05;
  localparam logic [7:0] SC_IDLE = 8'h20;
  localparam logic [7:0] SC_RRDY = 8'h21;
  localparam logic [7:0] SC_CSOF = 8'h27;
  localparam logic [7:0] SC_PSOF = 8'h47;
  localparam logic [7:0] SC_EXC = 8'hE0;
  localparam logic [7:0] SC_NK285 = 8'hE1;
  localparam logic [7:0] SC_PK285 = 8'hE2;
  localparam logic [7:0] SC_RDV = 8'hE4;

  // ----------------------------------------------------------------
  // Fixed ten-bit patterns, bit 9 is a, bit 0 is j
  // ----------------------------------------------------------------
  localparam logic [9:0] SYM_NK285 = 10'h0FA;
  localparam logic [9:0] SYM_PK285 = 10'h305;
  localparam logic [9:0] SYM_EXC_N = 10'h278;
  localparam logic [9:0] SYM_EXC_P = 10'h187;
  localparam logic [9:0] SYM_RDV_N = 10'h375;
  localparam logic [9:0] SYM_RDV_P = 10'h08A;

  localparam logic [7:0] D21_4 = 8'h95;
  localparam logic [7:0] D21_5 = 8'hB5;
  localparam logic [7:0] D10_2 = 8'h4A;

  // Primitive sequences are four characters long
  localparam logic [1:0] PRIM_FIRST = 2'h0;
  localparam logic [1:0] PRIM_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Host word layout: {send_violation_symbol, special_char_select, data}
  // ----------------------------------------------------------------
  localparam int W_SC = 8;
  localparam int W_VIOL = 9;
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 8;

  function automatic logic sc_reserved(input logic [7:0] c);
    sc_reserved = !(c <= SC_K_LAST || c == SC_IDLE || c == SC_RRDY || c == SC_CSOF ||
                    c == SC_PSOF || c == SC_EXC || c == SC_NK285 || c == SC_PK285 ||
                    c == SC_RDV);
  endfunction

  function automatic logic is_primitive(input logic [7:0] c);
    is_primitive = (c == SC_IDLE) || (c == SC_RRDY);
  endfunction

endpackage

/* rtl/special_link_if.sv */
`timescale 1ns/1ps
interface special_link_if;
  import special_codec_pkg::*;

  logic [BYTE_W-1:0] tx_data;
  logic tx_sc;
  logic tx_viol;
  logic tx_valid;
  logic tx_ready;
  logic [BYTE_W-1:0] rx_data;
  logic rx_sc;
  logic rx_valid;

  modport codec_mp (
    input tx_data, tx_sc, tx_viol, tx_valid,
    output tx_ready, rx_data, rx_sc, rx_valid
  );

  modport host_mp (
    output tx_data, tx_sc, tx_viol, tx_valid,
    input tx_ready, rx_data, rx_sc, rx_valid
  );
endinterface

/* rtl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("word_fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      count_reg <= count_next;
      // Registered full flag keeps the filling side free of a long path
      in_ready <= (count_next != (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule

/* rtl/special_codec.sv */
`timescale 1ns/1ps
module special_codec import special_codec_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  special_link_if.codec_mp host,
  input wire logic link_ready,
  output logic [SYM_W-1:0] link_tx_sym,
  output logic link_tx_valid,
  input wire logic [SYM_W-1:0] link_rx_sym,
  input wire logic link_rx_valid
);

  // ----------------------------------------------------------------
  // Code tables, negative disparity forms
  // ----------------------------------------------------------------
  localparam logic [5:0] SIX_B [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B
  };
  localparam logic [3:0] FOUR_B [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE
  };
  localparam logic [3:0] FOUR_ALT = 4'h7;
  localparam logic [5:0] SIX_K28 = 6'h0F;
  localparam logic [4:0] X_K28 = 5'h1C;
  localparam logic [2:0] Y_ALT = 3'h7;
  localparam logic [3:0] HALF_SYM = 4'h5;
  localparam logic [2:0] HALF_SIX = 3'h3;
  localparam int N_DATA = 256;
  localparam int N_K = 12;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  function automatic logic rd_after(input logic [SYM_W-1:0] s, input logic rd);
    logic [3:0] n;
    n = 4'($countones(s));
    rd_after = (n > HALF_SYM) ? 1'b1 : (n < HALF_SYM) ? 1'b0 : rd;
  endfunction

  // Twelve special K-characters, code 00..0B to the byte they encode
  function automatic logic [7:0] k_byte(input logic [7:0] c);
    unique case (c)
      8'h08: k_byte = 8'hF7;
      8'h09: k_byte = 8'hFB;
      8'h0A: k_byte = 8'hFD;
      8'h0B: k_byte = 8'hFE;
      default: k_byte = {c[2:0], X_K28};
    endcase
  endfunction

  function automatic logic [SYM_W-1:0] enc(input logic [7:0] b, input logic k,
                                           input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s;
    logic [3:0] f;
    logic [2:0] n6;
    logic r6;
    logic alt;
    logic k28;
    x = b[4:0];
    y = b[7:5];
    k28 = k && (x == X_K28);
    s = k28 ? SIX_K28 : SIX_B[x];
    n6 = 3'($countones(s));
    if (!k28 && rd && (n6 != HALF_SIX || x == 5'h07)) begin
      s = ~s;
    end
    n6 = 3'($countones(s));
    r6 = k28 ? 1'b1 : (n6 > HALF_SIX) ? 1'b1 : (n6 < HALF_SIX) ? 1'b0 : rd;
    alt = (y == Y_ALT) && (k || (!r6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                           (r6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    f = alt ? FOUR_ALT : FOUR_B[y];
    if (r6 && (y == 3'h0 || y == 3'h3 || y == 3'h4 || y == 3'h7)) begin
      f = ~f;
    end
    enc = {s, f};
    // K28 forms are whole-word complements of each other
    if (k28 && rd) begin
      enc = ~enc;
    end
  endfunction

  // Returns {special, byte}; searches the same tables the encoder uses
  function automatic logic [8:0] dec(input logic [SYM_W-1:0] s, input logic rd);
    logic hit;
    logic wrong;
    logic k_wrong;
    logic [8:0] res;
    logic [7:0] kb;
    hit = 1'b0;
    wrong = 1'b0;
    k_wrong = 1'b0;
    res = '0;
    for (int i = 0; i < N_DATA; i++) begin
      if (enc(8'(i), 1'b0, rd) == s) begin
        hit = 1'b1;
        res = {1'b0, 8'(i)};
      end else if (enc(8'(i), 1'b0, !rd) == s) begin
        wrong = 1'b1;
      end
    end
    for (int j = 0; j < N_K; j++) begin
      kb = k_byte(8'(j));
      if (enc(kb, 1'b1, rd) == s) begin
        hit = 1'b1;
        res = {1'b1, 8'(j)};
      end else if (enc(kb, 1'b1, !rd) == s) begin
        if (8'(j) == SC_K28_5) begin
          k_wrong = 1'b1;
        end else begin
          wrong = 1'b1;
        end
      end
    end
    if (hit) begin
      dec = res;
    // [RQ10] [RQ11] misplaced comma
    end else if (k_wrong) begin
      dec = {1'b1, rd ? SC_NK285 : SC_PK285};
    // [RQ12] disparity mismatch report
    end else if (wrong) begin
      dec = {1'b1, SC_RDV};
    // [RQ9] unknown character report
    end else begin
      dec = {1'b1, SC_EXC};
    end
  endfunction

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic tx_rd_reg;
  logic prim_act_reg;
  logic [7:0] prim_code_reg;
  logic [1:0] prim_pos_reg;
  logic [7:0] code;
  logic sc;
  logic viol;
  logic prim;
  logic [1:0] pos_next;
  logic [SYM_W-1:0] sym_next;

  // Link never idles on the wire: an empty host side sends the Idle primitive
  assign host.tx_ready = link_ready;
  assign code = host.tx_valid ? host.tx_data : SC_IDLE;
  assign sc = host.tx_valid ? host.tx_sc : 1'b1;
  assign viol = host.tx_valid && host.tx_viol;
  assign prim = !viol && sc && is_primitive(code);

  always_comb begin
    pos_next = PRIM_FIRST;
    // [RQ4] [RQ6] sequence continuation
    if (prim && prim_act_reg && code == prim_code_reg) begin
      pos_next = prim_pos_reg + 2'h1;
    end
    sym_next = enc(code, 1'b0, tx_rd_reg);
    if (viol) begin
      // [RQ9] violation input
      sym_next = tx_rd_reg ? SYM_EXC_P : SYM_EXC_N;
    end else if (prim) begin
      // [RQ4] [RQ6] primitive characters
      unique case (pos_next)
        2'h0: sym_next = SYM_NK285;
        2'h1: sym_next = enc(D21_4, 1'b0, tx_rd_reg);
        default: sym_next = enc((code == SC_IDLE) ? D21_5 : D10_2, 1'b0, tx_rd_reg);
      endcase
    end else if (sc) begin
      if (code <= SC_K_LAST) begin
        // [RQ1] [RQ3] K-character by disparity
        sym_next = enc(k_byte(code), 1'b1, tx_rd_reg);
      end else if (code == SC_CSOF || code == SC_PSOF) begin
        sym_next = enc(k_byte(SC_CSOF), 1'b1, tx_rd_reg);
      end else if (code == SC_NK285) begin
        // [RQ10] forced negative comma
        sym_next = SYM_NK285;
      end else if (code == SC_PK285) begin
        // [RQ11] forced positive comma
        sym_next = SYM_PK285;
      end else if (code == SC_RDV) begin
        // [RQ12] deliberate disparity error
        sym_next = tx_rd_reg ? SYM_RDV_P : SYM_RDV_N;
      end else begin
        // [RQ9] exception code, or [RQ2] reserved code with no defined meaning; send the exception
        sym_next = tx_rd_reg ? SYM_EXC_P : SYM_EXC_N;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      link_tx_sym <= '0;
      link_tx_valid <= 1'b0;
      tx_rd_reg <= 1'b0;
      prim_act_reg <= 1'b0;
      prim_code_reg <= '0;
      prim_pos_reg <= PRIM_FIRST;
    end else begin
      link_tx_valid <= link_ready;
      if (link_ready) begin
        link_tx_sym <= sym_next;
        // [RQ13] transmit disparity update
        tx_rd_reg <= rd_after(sym_next, tx_rd_reg);
        prim_act_reg <= prim;
        prim_code_reg <= code;
        prim_pos_reg <= pos_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic rx_rd_reg;
  logic [8:0] rx_dec;

  assign rx_dec = dec(link_rx_sym, rx_rd_reg);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rx_rd_reg <= 1'b0;
      host.rx_data <= '0;
      host.rx_sc <= 1'b0;
      host.rx_valid <= 1'b0;
    end else begin
      host.rx_valid <= link_rx_valid;
      if (link_rx_valid) begin
        // [RQ13] receive disparity update
        rx_rd_reg <= rd_after(link_rx_sym, rx_rd_reg);
        // [RQ8] comma decodes as K28.5 form
        host.rx_sc <= rx_dec[W_SC];
        host.rx_data <= rx_dec[BYTE_W-1:0];
      end
    end
  end
endmodule

/* rtl/special_host.sv */
`timescale 1ns/1ps
module special_host import special_codec_pkg::*; #(
  parameter int DEPTH = FIFO_D
) (
  input wire logic mclk,
  input wire logic resetn,
  special_link_if.host_mp link,
  input wire logic [BYTE_W-1:0] user_data,
  input wire logic user_sc,
  input wire logic user_viol,
  input wire logic user_valid,
  output logic user_ready,
  output logic user_drop,
  output logic [BYTE_W-1:0] user_rx_data,
  output logic user_rx_sc,
  output logic user_rx_valid
);

  logic [FIFO_W-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_take;
  logic [1:0] rep_reg;
  logic pop;
  logic reserved;

  // Queue absorbs user words while a primitive is being held
  word_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_data({user_viol, user_sc, user_data}),
    .in_valid(user_valid),
    .in_ready(user_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  assign fifo_take = !link.tx_valid || (link.tx_ready && rep_reg == PRIM_FIRST);
  assign pop = fifo_valid && fifo_take;
  assign reserved = fifo_out[W_SC] && sc_reserved(fifo_out[BYTE_W-1:0]);

  // ----------------------------------------------------------------
  // Presentation to the codec
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      link.tx_valid <= 1'b0;
      link.tx_data <= '0;
      link.tx_sc <= 1'b0;
      link.tx_viol <= 1'b0;
      rep_reg <= PRIM_FIRST;
      user_drop <= 1'b0;
    end else begin
      // [RQ2] reserved codes never reach the codec
      user_drop <= pop && reserved;
      if (link.tx_valid && link.tx_ready) begin
        if (rep_reg == PRIM_FIRST) begin
          link.tx_valid <= 1'b0;
        end else begin
          rep_reg <= rep_reg - 2'h1;
        end
      end
      if (pop && !reserved) begin
        link.tx_valid <= 1'b1;
        link.tx_data <= fifo_out[BYTE_W-1:0];
        link.tx_sc <= fifo_out[W_SC];
        link.tx_viol <= fifo_out[W_VIOL];
        // [RQ5] [RQ7] primitives held four byte times
        if (fifo_out[W_SC] && !fifo_out[W_VIOL] && is_primitive(fifo_out[BYTE_W-1:0])) begin
          rep_reg <= PRIM_LAST;
        end else begin
          rep_reg <= PRIM_FIRST;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Received bytes to the user
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      user_rx_data <= '0;
      user_rx_sc <= 1'b0;
      user_rx_valid <= 1'b0;
    end else begin
      user_rx_valid <= link.rx_valid;
      if (link.rx_valid) begin
        user_rx_data <= link.rx_data;
        user_rx_sc <= link.rx_sc;
      end
    end
  end
endmodule

/* dv/special_codec_asserts.sv */
`timescale 1ns/1ps
module special_codec_asserts import special_codec_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_sc,
  input wire logic tx_viol,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [BYTE_W-1:0] rx_data,
  input wire logic rx_sc,
  input wire logic rx_valid
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic taken;
  logic prim;
  logic [1:0] prim_cnt_reg;
  logic after_word_reg;
  assign taken = tx_valid && tx_ready;
  assign prim = tx_sc && !tx_viol && (tx_data == SC_IDLE || tx_data == SC_RRDY);

  // Beats of a primitive word taken so far, modulo four
  always_ff @(posedge mclk) begin
    if (!resetn) prim_cnt_reg <= 2'h0;
    else if (taken) prim_cnt_reg <= prim ? prim_cnt_reg + 2'h1 : 2'h0;
  end

  // A fill run may precede a host primitive, so only a word-led run has a known head
  always_ff @(posedge mclk) begin
    if (!resetn) after_word_reg <= 1'b0;
    else if (tx_ready) after_word_reg <= tx_valid && !prim;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_k_loopback: assert property (
    taken && tx_sc && !tx_viol && tx_data <= SC_K_LAST |->
      ##2 rx_valid && rx_sc && rx_data == $past(tx_data, 2)) else $error("K code lost");
  a_data_loopback: assert property (
    taken && !tx_sc && !tx_viol |->
      ##2 rx_valid && !rx_sc && rx_data == $past(tx_data, 2)) else $error("data lost");
  a_viol_exception: assert property (
    taken && (tx_viol || (tx_sc && tx_data == SC_EXC)) |->
      ##2 rx_valid && rx_sc && rx_data == SC_EXC) else $error("violation not seen");
  a_no_reserved: assert property (
    tx_valid && tx_sc && !tx_viol |-> !sc_reserved(tx_data)) else $error("reserved code");
  a_prim_whole: assert property (
    !tx_valid || (tx_ready && !prim) |-> prim_cnt_reg == 2'h0) else $error("primitive cut");
  a_prim_head: assert property (
    taken && prim && prim_cnt_reg == 2'h0 && after_word_reg |->
      ##2 rx_valid && rx_sc && (rx_data == SC_K28_5 || rx_data == SC_NK285))
    else $error("primitive head wrong");
  a_rx_no_prim: assert property (
    rx_valid && rx_sc |-> rx_data != SC_IDLE && rx_data != SC_RRDY) else $error("rx primitive");
  a_hold_stable: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_sc) && $stable(tx_viol))
    else $error("word changed while held");
  a_neg_force: assert property (
    taken && tx_sc && !tx_viol && tx_data == SC_NK285 |->
      ##2 rx_valid && rx_sc && (rx_data == SC_K28_5 || rx_data == SC_NK285))
    else $error("negative K28.5 wrong");
  a_pos_force: assert property (
    taken && tx_sc && !tx_viol && tx_data == SC_PK285 |->
      ##2 rx_valid && rx_sc && (rx_data == SC_K28_5 || rx_data == SC_PK285))
    else $error("positive K28.5 wrong");
endmodule

/* dv/special_char_8b10b_codec_tb_top.sv */
`timescale 1ns/1ps
`define CHECK_EQ(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module special_char_8b10b_codec_tb_top import special_codec_pkg::*;;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic link_ready = 1'b0;
  logic link_ready2 = 1'b0;
  logic [1:0] lr_mode = 2'h0;
  logic inj_sel = 1'b0;
  logic inj_valid = 1'b0;
  logic [SYM_W-1:0] inj_sym = 10'h000;
  logic [BYTE_W-1:0] user_data = 8'h00;
  logic user_sc = 1'b0;
  logic user_viol = 1'b0;
  logic user_valid = 1'b0;
  logic user_ready, user_drop, user_rx_sc, user_rx_valid, link_tx_valid, link_tx_valid2;
  logic [BYTE_W-1:0] user_rx_data;
  logic [SYM_W-1:0] link_tx_sym, link_tx_sym2, link_rx_sym;
  logic link_rx_valid;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int drops = 0;
  logic [8:0] rxq[$];
  logic [9:0] txq[$];
  logic [9:0] tx2q[$];

  always #4 mclk = ~mclk;

  special_link_if link_if();
  special_link_if link2_if();
  assign link_rx_sym = inj_sel ? inj_sym : link_tx_sym;
  assign link_rx_valid = inj_sel ? inj_valid : link_tx_valid;

  special_host special_host_inst (.mclk(mclk), .resetn(resetn), .link(link_if),
    .user_data(user_data), .user_sc(user_sc), .user_viol(user_viol), .user_valid(user_valid),
    .user_ready(user_ready), .user_drop(user_drop), .user_rx_data(user_rx_data),
    .user_rx_sc(user_rx_sc), .user_rx_valid(user_rx_valid));
  special_codec special_codec_inst (.mclk(mclk), .resetn(resetn), .host(link_if),
    .link_ready(link_ready), .link_tx_sym(link_tx_sym), .link_tx_valid(link_tx_valid),
    .link_rx_sym(link_rx_sym), .link_rx_valid(link_rx_valid));
  // Second codec faces a bench-driven host that breaks the hold rules
  special_codec special_codec_lone_inst (.mclk(mclk), .resetn(resetn), .host(link2_if),
    .link_ready(link_ready2), .link_tx_sym(link_tx_sym2), .link_tx_valid(link_tx_valid2),
    .link_rx_sym(10'h000), .link_rx_valid(1'b0));
  special_codec_asserts special_codec_asserts_inst (.mclk(mclk), .resetn(resetn),
    .tx_data(link_if.tx_data), .tx_sc(link_if.tx_sc), .tx_viol(link_if.tx_viol),
    .tx_valid(link_if.tx_valid), .tx_ready(link_if.tx_ready), .rx_data(link_if.rx_data),
    .rx_sc(link_if.rx_sc), .rx_valid(link_if.rx_valid));

  // ----------------------------------------
  // Monitors, link pacing and timeout
  // ----------------------------------------
  always @(negedge mclk) begin
    if (user_rx_valid === 1'b1) rxq.push_back({user_rx_sc, user_rx_data});
    if (link_tx_valid === 1'b1) txq.push_back(link_tx_sym);
    if (link_tx_valid2 === 1'b1) tx2q.push_back(link_tx_sym2);
    if (user_drop === 1'b1) drops++;
  end

  // Mode 2 stalls the serializer one cycle in four
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    link_ready <= (lr_mode == 2'h2) ? (cyc[1:0] != 2'h0) : lr_mode[0];
    if (cyc == LIMIT) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset;
    resetn = 1'b0;
    lr_mode = 2'h0;
    repeat (12) @(negedge mclk);
    rxq.delete();
    txq.delete();
    tx2q.delete();
    drops = 0;
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
  endtask

  task automatic push(input logic [9:0] w);
    {user_viol, user_sc, user_data} = w;
    user_valid = 1'b1;
    while (user_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask

  task automatic wait_rx(input int n);
    int k = 0;
    while (rxq.size() < n && k < 300) begin
      @(negedge mclk);
      k++;
    end
  endtask

  task automatic t_inject;
    logic [9:0] syms[6] = '{10'h30B, 10'h305, 10'h0FA, 10'h0FA, 10'h3FF, 10'h18B};
    logic [8:0] exp[6] = '{9'h1E4, 9'h1E2, 9'h105, 9'h1E1, 9'h1E0, 9'h000};
    do_reset();
    inj_sel = 1'b1;
    foreach (syms[i]) begin
      inj_sym = syms[i];
      inj_valid = 1'b1;
      @(negedge mclk);
    end
    inj_valid = 1'b0;
    wait_rx(6);
    foreach (exp[i]) `CHECK_EQ(rxq[i], exp[i])
    inj_sel = 1'b0;
  endtask

  // K codes through a full buffer and a stalling link
  task automatic t_kcodes;
    do_reset();
    for (int i = 0; i < 9; i++) push({2'h1, i[7:0]});
    {user_viol, user_sc, user_data} = {2'h1, 8'h09};
    repeat (3) @(negedge mclk);
    `CHECK_EQ(user_ready, 1'b0)
    lr_mode = 2'h2;
    for (int i = 9; i < 12; i++) push({2'h1, i[7:0]});
    user_valid = 1'b0;
    wait_rx(12);
    for (int i = 0; i < 12; i++) `CHECK_EQ(rxq[i], {1'b1, i[7:0]})
    `CHECK_EQ(txq[0], 10'h0F4)
    `CHECK_EQ(txq[1], 10'h0F9)
    `CHECK_EQ(user_ready, 1'b1)
  endtask

  task automatic t_prims;
    logic [8:0] exp[11] = '{9'h105, 9'h1E1, 9'h095, 9'h0B5, 9'h0B5, 9'h105, 9'h095,
                            9'h04A, 9'h04A, 9'h1E2, 9'h03C};
    do_reset();
    push({2'h1, SC_NK285});
    push({2'h1, SC_IDLE});
    push({2'h1, SC_RRDY});
    push({2'h1, SC_PK285});
    push({2'h0, 8'h3C});
    user_valid = 1'b0;
    lr_mode = 2'h1;
    wait_rx(11);
    foreach (exp[i]) `CHECK_EQ(rxq[i], exp[i])
    `CHECK_EQ(txq[1], SYM_NK285)
    `CHECK_EQ(txq[9], SYM_PK285)
  endtask

  task automatic t_errors;
    do_reset();
    push({2'h2, 8'h55});
    push({2'h1, SC_EXC});
    push({2'h1, 8'h30});
    push({2'h1, SC_RDV});
    push({2'h0, 8'h77});
    user_valid = 1'b0;
    lr_mode = 2'h1;
    wait_rx(5);
    // Dropped word leaves the host empty for one beat, so a lone Idle comma
    // goes out and moves the disparity positive before the violation pattern
    `CHECK_EQ(rxq[0], 9'h1E0)
    `CHECK_EQ(rxq[1], 9'h1E0)
    `CHECK_EQ(rxq[2], 9'h105)
    `CHECK_EQ(rxq[3], 9'h1E0)
    `CHECK_EQ(rxq[4], 9'h077)
    `CHECK_EQ(txq[0], SYM_EXC_N)
    `CHECK_EQ(txq[1], SYM_EXC_N)
    `CHECK_EQ(txq[2], SYM_NK285)
    `CHECK_EQ(txq[3], SYM_RDV_P)
    `CHECK_EQ(drops, 1)
  endtask

  // one-beat Idle and a reserved code from a faulty host
  task automatic t_lone;
    logic [9:0] w[4] = '{10'h000, {2'h1, SC_IDLE}, 10'h000, 10'h130};
    logic [9:0] exp[4] = '{10'h274, SYM_NK285, 10'h18B, SYM_EXC_P};
    do_reset();
    link_ready2 = 1'b1;
    foreach (w[i]) begin
      {link2_if.tx_viol, link2_if.tx_sc, link2_if.tx_data} = w[i];
      link2_if.tx_valid = 1'b1;
      @(negedge mclk);
    end
    link2_if.tx_valid = 1'b0;
    link_ready2 = 1'b0;
    repeat (3) @(negedge mclk);
    foreach (exp[i]) `CHECK_EQ(tx2q[i], exp[i])
  endtask

  initial begin
    {link2_if.tx_viol, link2_if.tx_sc, link2_if.tx_data} = 10'h000;
    link2_if.tx_valid = 1'b0;
    t_inject();
    t_kcodes();
    t_prims();
    t_errors();
    t_lone();
    results();
  end
endmodule
